// ### logic/dbd_pkg.sv
// shared constants and types for the double-buffer dma channels
package dbd_pkg;
  localparam int          NUM_CH        = 6;
  localparam int          CNT_W         = 13;
  localparam int          ADDR_W        = 32;
  localparam int          REG_AW        = 8;
  // per-channel register word offsets (channel stride 0x20)
  localparam logic [7:0]  CH_STRIDE     = 8'h20;
  localparam logic [4:0]  OFS_CSR_SET   = 5'h04;
  localparam logic [4:0]  OFS_CSR_CLR   = 5'h08;
  localparam logic [4:0]  OFS_CSR_RD    = 5'h0C;
  localparam logic [4:0]  OFS_SA_A      = 5'h10;
  localparam logic [4:0]  OFS_CNT_A     = 5'h14;
  localparam logic [4:0]  OFS_SA_B      = 5'h18;
  localparam logic [4:0]  OFS_CNT_B     = 5'h1C;
  // control/status field positions
  localparam int          BIT_RUN       = 0;
  localparam int          BIT_IE        = 1;
  localparam int          BIT_ERR       = 2;
  localparam int          BIT_FIN_A     = 3;
  localparam int          BIT_GO_A      = 4;
  localparam int          BIT_FIN_B     = 5;
  localparam int          BIT_GO_B      = 6;
  localparam int          BIT_SEL       = 7;
  // bytes moved per access and accesses per burst
  localparam logic [12:0] BYTES_PER_XFR = 13'h0004;
  localparam logic [3:0]  BURST_LEN     = 4'h4;
  typedef enum logic [1:0] {
    DBD_IDLE  = 2'b00,
    DBD_GRANT = 2'b01,
    DBD_XFER  = 2'b10,
    DBD_END   = 2'b11
  } dbd_state_t;
endpackage

// ### logic/dbd_if.sv
// link between the dma engine and the peripheral side
`timescale 1ns/1ps
interface dbd_if;
  logic [dbd_pkg::NUM_CH-1:0] req;
  logic [dbd_pkg::NUM_CH-1:0] ack;
  logic [31:0]                addr;
  logic                       xfer;
  logic                       err;
  modport engine (input req, input err, output ack, output addr, output xfer);
  modport periph (output req, output err, input ack, input addr, input xfer);
endinterface

// ### logic/dbd_engine.sv
// six-channel double-buffer dma engine with register port
`timescale 1ns/1ps
// How it works
// - per-channel 32-bit first buffer start address
// - software writes it only while go clear
// - first count readable, shows remaining bytes
// - software writes first count only when idle
// - per-channel 32-bit second buffer start address
// - second address written only while go clear
// - second count readable, shows remaining bytes
// - second count written only while go clear
// - count field is low thirteen bits
// - upper count bits read zero, ignore writes
// - memory port shared among requesting channels
// - switch only at burst or buffer end
// - idle requester yields to other requesters
// - fixed priority, channel zero highest
// - select bit toggles on each finish
// - finish sets done, clears go bit
// - run bit gates transfers, pause after burst
// - interrupt while enabled and any flag
module dbd_engine #(
  parameter int NCH = dbd_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             resetn,
  // register port
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  output logic      [31:0]      reg_rdata,
  // per-channel interrupts
  output logic      [NCH-1:0]   ch_irq,
  // link to the peripheral side
  dbd_if.engine                 lnk
);
  // the link is sized by the package and the channel index is three bits wide
  if (NCH != dbd_pkg::NUM_CH || NCH > 8) begin : g_bad_nch
    $error("channel count unsupported");
  end

  logic [31:0]         sa_a_r   [NCH];
  logic [31:0]         sa_b_r   [NCH];
  logic [31:0]         ptr_r    [NCH];
  logic [12:0]         cnt_a_r  [NCH];
  logic [12:0]         cnt_b_r  [NCH];
  logic [7:0]          csr_r    [NCH];
  logic                loaded_r [NCH];
  dbd_pkg::dbd_state_t st_r;
  logic [2:0]          cur_r;
  logic [3:0]          beat_r;
  logic [NCH-1:0]      ack_r;
  logic [31:0]         addr_r;
  logic                xfer_r;
  logic [31:0]         rdata_r;
  logic [NCH-1:0]      irq_r;

  // register decode shared by the write and read paths
  wire  [2:0]  rch   = 3'(reg_addr[7:5]);
  wire  [4:0]  rofs  = reg_addr[4:0];
  wire         rhit  = 32'(rch) < NCH;

  // a channel is eligible when running, requesting and its active buffer started
  logic [NCH-1:0] elig;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_elig
      assign elig[g] = csr_r[g][dbd_pkg::BIT_RUN] & lnk.req[g] &
                       (csr_r[g][dbd_pkg::BIT_SEL] ? csr_r[g][dbd_pkg::BIT_GO_B]
                                                   : csr_r[g][dbd_pkg::BIT_GO_A]);
    end
  endgenerate

  function automatic logic [2:0] pick(input logic [NCH-1:0] v);
    logic [2:0] p;
    p = 3'h0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        p = 3'(i);
      end
    end
    return p;
  endfunction

  wire  [2:0]  win     = pick(elig);
  wire         cur_sel = csr_r[cur_r][dbd_pkg::BIT_SEL];
  wire  [12:0] cur_cnt = cur_sel ? cnt_b_r[cur_r] : cnt_a_r[cur_r];
  wire         last    = cur_cnt <= dbd_pkg::BYTES_PER_XFR;
  // a burst or the buffer ends here, the only switch points
  wire         burst_end = last | (beat_r == dbd_pkg::BURST_LEN - 4'h1);
  wire         beat    = (st_r == dbd_pkg::DBD_XFER);
  wire         fin     = beat & last;

  // arbiter state machine, rearbitrates after every burst
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r   <= dbd_pkg::DBD_IDLE;
      cur_r  <= 3'h0;
      beat_r <= 4'h0;
    end else begin
      case (st_r)
        dbd_pkg::DBD_IDLE: begin
          // only requesting channels win, an idle one is skipped
          if (|elig) begin
            cur_r <= win;
            st_r  <= dbd_pkg::DBD_GRANT;
          end
        end
        dbd_pkg::DBD_GRANT: begin
          beat_r <= 4'h0;
          st_r   <= dbd_pkg::DBD_XFER;
        end
        dbd_pkg::DBD_XFER: begin
          beat_r <= beat_r + 4'h1;
          // a cleared run bit only takes effect at burst end
          if (burst_end) begin
            st_r <= dbd_pkg::DBD_END;
          end
        end
        dbd_pkg::DBD_END: st_r <= dbd_pkg::DBD_IDLE;
        default: st_r <= dbd_pkg::DBD_IDLE;
      endcase
    end
  end

  // link outputs registered
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r  <= '0;
      addr_r <= 32'h0000_0000;
      xfer_r <= 1'b0;
    end else begin
      xfer_r <= beat;
      addr_r <= ptr_r[cur_r];
      ack_r  <= beat ? NCH'(1) << cur_r : '0;
    end
  end

  // per-channel registers and status
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire       wsel    = reg_wr & rhit & (rch == 3'(g));
      wire       me_beat = beat & (cur_r == 3'(g));
      wire       fin_me  = fin & (cur_r == 3'(g));
      wire [7:0] setm    = (wsel && rofs == dbd_pkg::OFS_CSR_SET) ? reg_wdata[7:0] : 8'h00;
      wire [7:0] clrm    = (wsel && rofs == dbd_pkg::OFS_CSR_CLR) ? reg_wdata[7:0] : 8'h00;
      wire       go_a_up = setm[dbd_pkg::BIT_GO_A] & ~csr_r[g][dbd_pkg::BIT_GO_A];
      wire       go_b_up = setm[dbd_pkg::BIT_GO_B] & ~csr_r[g][dbd_pkg::BIT_GO_B];
      wire       sel     = csr_r[g][dbd_pkg::BIT_SEL];
      wire       err_ev  = lnk.err & me_beat;
      logic [7:0] c_nxt;
      always_comb begin
        c_nxt = csr_r[g];
        c_nxt[dbd_pkg::BIT_RUN] = (c_nxt[dbd_pkg::BIT_RUN] | setm[dbd_pkg::BIT_RUN]) & ~clrm[dbd_pkg::BIT_RUN];
        c_nxt[dbd_pkg::BIT_IE]  = (c_nxt[dbd_pkg::BIT_IE] | setm[dbd_pkg::BIT_IE]) & ~clrm[dbd_pkg::BIT_IE];
        c_nxt[dbd_pkg::BIT_GO_A] = (c_nxt[dbd_pkg::BIT_GO_A] | setm[dbd_pkg::BIT_GO_A]) & ~clrm[dbd_pkg::BIT_GO_A];
        c_nxt[dbd_pkg::BIT_GO_B] = (c_nxt[dbd_pkg::BIT_GO_B] | setm[dbd_pkg::BIT_GO_B]) & ~clrm[dbd_pkg::BIT_GO_B];
        // done flags clear on write-one or start, but a finish wins
        if (clrm[dbd_pkg::BIT_FIN_A] | go_a_up) c_nxt[dbd_pkg::BIT_FIN_A] = 1'b0;
        if (clrm[dbd_pkg::BIT_FIN_B] | go_b_up) c_nxt[dbd_pkg::BIT_FIN_B] = 1'b0;
        // error clears by setting run, a new error wins
        if (setm[dbd_pkg::BIT_RUN]) c_nxt[dbd_pkg::BIT_ERR] = 1'b0;
        if (err_ev) c_nxt[dbd_pkg::BIT_ERR] = 1'b1;
        // finish sets done and drops go
        if (fin_me) begin
          c_nxt[sel ? dbd_pkg::BIT_FIN_B : dbd_pkg::BIT_FIN_A] = 1'b1;
          c_nxt[sel ? dbd_pkg::BIT_GO_B : dbd_pkg::BIT_GO_A]   = 1'b0;
          c_nxt[dbd_pkg::BIT_SEL] = ~sel;
        end
      end

      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          csr_r[g]    <= 8'h00;
          loaded_r[g] <= 1'b0;
        end else begin
          csr_r[g] <= c_nxt;
          // pointer reloads when the active buffer changes or restarts;
          // arming the idle buffer must not rewind the one in flight
          loaded_r[g] <= me_beat ? ~fin_me : (loaded_r[g] & ~(sel ? go_b_up : go_a_up));
        end
      end

      // start addresses; writes assumed only while go clear
      // only the count field is stored
      // pointer advances and count falls per access
      always_ff @(posedge core_clk) begin
        if (wsel && rofs == dbd_pkg::OFS_SA_A) sa_a_r[g] <= reg_wdata;
        if (wsel && rofs == dbd_pkg::OFS_SA_B) sa_b_r[g] <= reg_wdata;
        if (wsel && rofs == dbd_pkg::OFS_CNT_A) begin
          cnt_a_r[g] <= reg_wdata[12:0];
        end else if (me_beat && !sel) begin
          cnt_a_r[g] <= last ? 13'h0000 : cnt_a_r[g] - dbd_pkg::BYTES_PER_XFR;
        end
        if (wsel && rofs == dbd_pkg::OFS_CNT_B) begin
          cnt_b_r[g] <= reg_wdata[12:0];
        end else if (me_beat && sel) begin
          cnt_b_r[g] <= last ? 13'h0000 : cnt_b_r[g] - dbd_pkg::BYTES_PER_XFR;
        end
        if (me_beat) begin
          ptr_r[g] <= (loaded_r[g] ? ptr_r[g] : (sel ? sa_b_r[g] : sa_a_r[g])) + 32'(dbd_pkg::BYTES_PER_XFR);
        end else if (!loaded_r[g]) begin
          ptr_r[g] <= sel ? sa_b_r[g] : sa_a_r[g];
        end
      end

      // interrupt while enabled and any flag set
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) irq_r[g] <= 1'b0;
        else irq_r[g] <= csr_r[g][dbd_pkg::BIT_IE] & (csr_r[g][dbd_pkg::BIT_ERR] |
                         csr_r[g][dbd_pkg::BIT_FIN_A] | csr_r[g][dbd_pkg::BIT_FIN_B]);
      end
    end
  endgenerate

  // read mux; unmapped words read zero
  wire [31:0] rd_mux =
    !rhit                         ? 32'h0000_0000 :
    (rofs == dbd_pkg::OFS_CSR_RD) ? {24'h00_0000, csr_r[rch]} :
    (rofs == dbd_pkg::OFS_SA_A)   ? sa_a_r[rch] :
    (rofs == dbd_pkg::OFS_CNT_A)  ? {19'h0_0000, cnt_a_r[rch]} :
    (rofs == dbd_pkg::OFS_SA_B)   ? sa_b_r[rch] :
    (rofs == dbd_pkg::OFS_CNT_B)  ? {19'h0_0000, cnt_b_r[rch]} : 32'h0000_0000;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) rdata_r <= 32'h0000_0000;
    else if (reg_rd) rdata_r <= rd_mux;
  end

  assign reg_rdata = rdata_r;
  assign ch_irq    = irq_r;
  assign lnk.ack   = ack_r;
  assign lnk.addr  = addr_r;
  assign lnk.xfer  = xfer_r;
endmodule

// ### logic/dbd_periph.sv
// peripheral end: raises service requests from a per-channel demand level
`timescale 1ns/1ps
module dbd_periph #(
  parameter int NCH = dbd_pkg::NUM_CH
) (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           resetn,
  // user side: demand per channel, bad-address flag
  input  wire logic [NCH-1:0] want,
  input  wire logic           bad_access,
  output logic      [NCH-1:0] served,
  output logic      [31:0]    served_addr,
  // link to the engine
  dbd_if.periph               lnk
);
  logic [NCH-1:0] req_r;
  logic           err_r;
  logic [NCH-1:0] served_r;
  logic [31:0]    saddr_r;

  // the link is sized by the package, so the channel count must match it
  if (NCH != dbd_pkg::NUM_CH) begin : g_bad_nch
    $error("channel count must match the link width");
  end

  // dropping demand lets the engine switch away at the burst end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      req_r    <= '0;
      err_r    <= 1'b0;
      served_r <= '0;
      saddr_r  <= 32'h0000_0000;
    end else begin
      req_r    <= want;
      err_r    <= bad_access;
      served_r <= lnk.xfer ? lnk.ack : '0;
      saddr_r  <= lnk.xfer ? lnk.addr : saddr_r;
    end
  end

  assign lnk.req     = req_r;
  assign lnk.err     = err_r;
  assign served      = served_r;
  assign served_addr = saddr_r;
endmodule

// ### dv/dbd_link_checker.sv
// assertion checker for the engine-to-peripheral link
`timescale 1ns/1ps
module dbd_link_checker (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       resetn,
  // link signals
  input wire logic [dbd_pkg::NUM_CH-1:0] req,
  input wire logic [dbd_pkg::NUM_CH-1:0] ack,
  input wire logic [31:0]                addr,
  input wire logic                       xfer,
  input wire logic                       err
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // gap after a burst, long silence on requests
  sequence gap_s;
    !xfer ##1 !xfer;
  endsequence
  sequence no_req_s;
    (req == '0) [*8];
  endsequence
  // beats carry one grant, never a stray one
  AST_ONE_GRANT: assert property (xfer |-> $onehot(ack))
    else $error("ack not one-hot during a beat");
  AST_NO_STRAY_ACK: assert property (!xfer |-> ack == '0)
    else $error("ack outside a beat");
  AST_REQ_BEHIND: assert property ($rose(xfer) |-> |(ack & ($past(req, 2) | $past(req, 3) | $past(req, 4))))
    else $error("burst for a channel that did not request");
  // switching only between bursts
  AST_BURST_MAX: assert property (xfer [*4] |=> !xfer)
    else $error("burst longer than four beats");
  AST_BURST_GAP: assert property ($fell(xfer) |-> gap_s)
    else $error("burst gap too short");
  AST_HOLD_CH: assert property (xfer && $past(xfer) |-> ack == $past(ack))
    else $error("channel switched inside a burst");
  AST_ADDR_STEP: assert property (xfer && $past(xfer) |-> addr == $past(addr) + 32'h0000_0004)
    else $error("beat address did not step by four");
  // a silent peripheral side lets the port go idle
  AST_QUIET: assert property (no_req_s |-> !xfer)
    else $error("beat with no request pending");
endmodule

// ### dv/double_buffer_dma_channels_tb.sv
// self-checking bench for the dma engine facing its peripheral end
`timescale 1ns/1ps
module double_buffer_dma_channels_tb;
  logic        core_clk, resetn, reg_wr, reg_rd, bad_access, rd_d;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, served_addr, seed;
  logic [5:0]  ch_irq, want, served;
  int          miscompares, check_count, cycles;
  logic [31:0] rd_q[$];
  logic [37:0] beat_q[$];
  dbd_if i_dbd_if ();
  dbd_engine i_dbd_engine (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ch_irq(ch_irq), .lnk(i_dbd_if));
  dbd_periph i_dbd_periph (.core_clk(core_clk), .resetn(resetn), .want(want), .bad_access(bad_access),
    .served(served), .served_addr(served_addr), .lnk(i_dbd_if));
  dbd_link_checker u_chk (.core_clk(core_clk), .resetn(resetn), .req(i_dbd_if.req), .ack(i_dbd_if.ack),
    .addr(i_dbd_if.addr), .xfer(i_dbd_if.xfer), .err(i_dbd_if.err));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic cmp(input logic [37:0] exp, input logic [37:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  // one compare per kind of result, all counted by cmp
  task automatic cmp_rd(input logic [31:0] exp, input logic [31:0] got);
    cmp({6'h00, exp}, {6'h00, got});
  endtask
  task automatic cmp_beat(input logic [37:0] exp, input logic [37:0] got);
    cmp(exp, got);
  endtask
  task automatic cmp_irq(input logic [5:0] exp, input logic [5:0] got);
    cmp({32'h0000_0000, exp}, {32'h0000_0000, got});
  endtask
  task automatic end_sim();
    miscompares += beat_q.size() + rd_q.size();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one register access; a read notes its expected word
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    if (!wr)
      rd_q.push_back(exp);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  // load buffer one of a channel, set its csr, note the beats it owes
  // start and count written while go clear
  task automatic arm(input int c, input logic [31:0] sa, input logic [12:0] n, input logic [31:0] csr);
    bus(1'b1, 8'(c * 32 + 16), sa, '0);
    bus(1'b1, 8'(c * 32 + 20), {19'h0, n}, '0);
    bus(1'b1, 8'(c * 32 + 4), csr, '0);
    for (int i = 0; i < (csr[0] ? n / 4 : 0); i++)
      beat_q.push_back({6'(1 << c), sa + 32'(i * 4)});
  endtask
  // read answers land one edge after the strobe; beats as served pulses
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    cycles <= cycles + 1;
    if (rd_d)
      cmp_rd(rd_q.size() > 0 ? rd_q.pop_front() : 32'hx, reg_rdata);
    if (served != '0)
      cmp_beat(beat_q.size() > 0 ? beat_q.pop_front() : 38'hx, {served, served_addr});
    if (cycles == 30000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {resetn, reg_wr, reg_rd, bad_access, rd_d, reg_addr, reg_wdata, want, cycles} = '0;
    seed = 32'h0001_7B74;
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    // random words into all buffer registers, counts keep thirteen bits
    // every go bit is still clear here
    for (int c = 0; c < 6; c++) begin
      for (int w = 0; w < 4; w++) begin
        seed = next_rnd(seed);
        bus(1'b1, 8'(c * 32 + 16 + w * 4), seed, '0);
        bus(1'b0, 8'(c * 32 + 16 + w * 4), '0, w[0] ? {19'h0, seed[12:0]} : seed);
      end
    end
    bus(1'b0, 8'hC0, '0, '0);
    bus(1'b0, 8'h00, '0, '0);
    // both buffers of channel 2 back to back: six beats then two
    bus(1'b1, 8'h58, 32'h2000_0100, '0);
    bus(1'b1, 8'h5C, 32'h0000_0008, '0);
    arm(2, 32'h1000_0000, 13'h0018, 32'h0000_0053);
    beat_q.push_back({6'h04, 32'h2000_0100});
    beat_q.push_back({6'h04, 32'h2000_0104});
    want <= 6'h04;
    for (int i = 0; i < 300 && beat_q.size() > 0; i++)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
    bus(1'b0, 8'h4C, '0, 32'h0000_002B);
    bus(1'b0, 8'h54, '0, '0);
    bus(1'b0, 8'h5C, '0, '0);
    cmp_irq(6'h04, ch_irq);
    want <= 6'h00;
    bus(1'b1, 8'h48, 32'h0000_0028, '0);
    repeat (2) @(posedge core_clk);
    cmp_irq(6'h00, ch_irq);
    // channels 1 and 4 ask together; 5 has no run bit and must stay silent
    // a bad access held through every beat raises the error flag; only 4 has irq enable
    arm(4, 32'h3000_0000, 13'h0020, 32'h0000_0013);
    arm(5, 32'h5000_0000, 13'h0010, 32'h0000_0010);
    arm(1, 32'h4000_0000, 13'h0010, 32'h0000_0011);
    beat_q = {beat_q[8:11], beat_q[0:7]};
    want <= 6'h32;
    bad_access <= 1'b1;
    for (int i = 0; i < 300 && beat_q.size() > 0; i++)
      @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    want <= 6'h00;
    bad_access <= 1'b0;
    bus(1'b0, 8'h2C, '0, 32'h0000_008D);
    bus(1'b0, 8'h8C, '0, 32'h0000_008F);
    bus(1'b0, 8'hAC, '0, 32'h0000_0010);
    bus(1'b0, 8'h94, '0, '0);
    cmp_irq(6'h10, ch_irq);
    // setting run again clears the error, done keeps the interrupt up
    bus(1'b1, 8'h84, 32'h0000_0001, '0);
    bus(1'b0, 8'h8C, '0, 32'h0000_008B);
    cmp_irq(6'h10, ch_irq);
    bus(1'b1, 8'h88, 32'h0000_0008, '0);
    repeat (2) @(posedge core_clk);
    cmp_irq(6'h00, ch_irq);
    end_sim();
  end
endmodule
